// [common/smp_pkg.sv]
// shared constants and types of the synchronous memory port
package smp_pkg;

	localparam int ADDR_W    = 20;
	localparam int DATA_W    = 16;
	localparam int CS_W      = 4;
	localparam int BE_W      = 2;

	// default burst length of both memory kinds, in words
	localparam int BURST_LEN = 4;
	// read latencies in memory clock periods
	localparam int SD_CAS_LAT = 3;
	localparam int SS_RD_LAT  = 2;
	localparam int RD_PIPE_W  = 4;

	// hold handshake windows, in mem_clk_in periods
	localparam logic [2:0] FLOAT_MIN_E   = 3'h2;
	localparam logic [2:0] REDRIVE_MIN_E = 3'h2;
	localparam logic [2:0] REDRIVE_MAX_E = 3'h7;

	// precharge-all flag sits on ext_addr line 10, index 8 here
	localparam int PRE_ALL_BIT = 8;

	// reset values
	localparam logic [CS_W-1:0]   CS_IDLE   = 4'hf;
	localparam logic [BE_W-1:0]   BE_IDLE   = 2'h3;
	localparam logic [ADDR_W-1:0] ADDR_RST  = 20'h00000;
	localparam logic [DATA_W-1:0] DATA_RST  = 16'h0000;

	typedef enum logic [2:0] {
		CMD_READ  = 3'b000,
		CMD_WRITE = 3'b001,
		CMD_ROW_ACTIVATE_CMD  = 3'b010,
		CMD_PREA  = 3'b011,
		CMD_DEACT = 3'b100,
		CMD_REFRESH_CMD  = 3'b101,
		CMD_MRS   = 3'b110,
		CMD_NOP   = 3'b111
	} smp_cmd_type;

	// sdram command code, bit order {row, col, write} strobes
	localparam logic [2:0] SD_NOP   = 3'h7;
	localparam logic [2:0] SD_ROW_ACTIVATE_CMD  = 3'h3;
	localparam logic [2:0] SD_READ  = 3'h5;
	localparam logic [2:0] SD_WRITE = 3'h4;
	localparam logic [2:0] SD_PRE   = 3'h2;
	localparam logic [2:0] SD_REFRESH_CMD  = 3'h1;
	localparam logic [2:0] SD_MRS   = 3'h0;

	typedef enum logic [2:0] {
		HOLD_IDLE    = 3'b000,
		HOLD_DRAIN   = 3'b001,
		HOLD_FLOAT   = 3'b010,
		HOLD_GRANTED = 3'b011,
		HOLD_REDRIVE = 3'b100
	} smp_hold_type;

endpackage : smp_pkg

// [design/smp_mem_port.sv]
// synchronous memory port: burst sram, sdram commands and bus hold
// How it works
// - burst sram: one address strobe, memory counts four incrementing words
// - sdram: each access is a four-word incrementing burst on its counter
// - a new command cuts off the running burst for random or down order
// - words of every burst flow on back-to-back memory clock edges
// - sram mode: shared pins are address strobe, output enable, write
// - sdram mode: shared pins are column strobe, row strobe, write strobe
// - sdram read data is taken three memory clocks after the command
// - also issues activate, precharge all, deactivate, refresh, mode set
// - outputs change and read data is sampled on rising mem_clk_out only
// - on bus request, finish pending work before floating and granting
// - float no sooner than two input clocks after request goes low
// - grant goes low within two input clocks of floating
// - drive again two to seven input clocks after request goes high
// - grant goes high within two input clocks of driving again
// - with hold_refuse set while idle the bus is never granted
// - floated pins: selects, byte enables, data, address, three strobes
`timescale 1ns/1ps

module smp_mem_port
	import smp_pkg::*;
(
	input  wire logic               ref_clk,
	input  wire logic               rst_b,
	input  wire logic               clk_en,
	input  wire logic               mem_clk_in,
	output logic                    mem_clk_out,
	input  wire logic               req_valid,
	output logic                    req_ready,
	input  wire smp_cmd_type        req_cmd,
	input  wire logic               req_sdram,
	input  wire logic [1:0]         req_cs,
	input  wire logic [ADDR_W-1:0]  req_addr,
	input  wire logic [BE_W-1:0]    req_be_n,
	input  wire logic [DATA_W-1:0]  wr_data,
	output logic                    wr_take,
	output logic [DATA_W-1:0]       rd_data,
	output logic                    rd_valid,
	output logic [CS_W-1:0]         chip_select_n,
	output logic [BE_W-1:0]         byte_enable_n,
	output logic [ADDR_W-1:0]       ext_addr,
	output logic [DATA_W-1:0]       ext_data_out,
	input  wire logic [DATA_W-1:0]  ext_data_in,
	output logic                    ext_data_oe_n,
	output logic                    rd_strobe_pin_n,
	output logic                    oe_strobe_pin_n,
	output logic                    wr_strobe_pin_n,
	output logic                    bus_oe_n,
	input  wire logic               hold_refuse,
	input  wire logic               ext_bus_req_n,
	output logic                    ext_bus_grant_n
);

	// refused at elaboration: the pipe taps and the two-bit beat count
	if (SD_CAS_LAT > RD_PIPE_W || SS_RD_LAT > RD_PIPE_W ||
	    SD_CAS_LAT < 1 || SS_RD_LAT < 1 || RD_PIPE_W < 2 ||
	    BURST_LEN < 1 || BURST_LEN > 4) begin : g_bad_cfg
		$error("read latency or burst length does not fit the logic");
	end

	////////////////////////////////////////////////////////////////////
	// pin synchronisers and memory clock edge

	logic                mck_s1_ff, mck_s2_ff, mck_out_ff;
	logic                breq_s1_ff, breq_s2_ff;
	logic [DATA_W-1:0]   din_s1_ff, din_s2_ff;

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			mck_s1_ff  <= 1'b0;
			mck_s2_ff  <= 1'b0;
			mck_out_ff <= 1'b0;
			breq_s1_ff <= 1'b1;
			breq_s2_ff <= 1'b1;
			din_s1_ff  <= DATA_RST;
			din_s2_ff  <= DATA_RST;
		end else if (clk_en) begin
			mck_s1_ff  <= mem_clk_in;
			mck_s2_ff  <= mck_s1_ff;
			mck_out_ff <= mck_s2_ff;
			breq_s1_ff <= ext_bus_req_n;
			breq_s2_ff <= breq_s1_ff;
			din_s1_ff  <= ext_data_in;
			din_s2_ff  <= din_s1_ff;
		end
	end

	// every pin update rides on this, the cycle mem_clk_out rises
	wire mem_rise = clk_en & mck_s2_ff & ~mck_out_ff;

	////////////////////////////////////////////////////////////////////
	// request holding slot

	logic                pend_ff, p_sd_ff, req_ready_ff;
	smp_cmd_type         p_cmd_ff;
	logic [1:0]          p_cs_ff;
	logic [ADDR_W-1:0]   p_addr_ff;
	logic [BE_W-1:0]     p_be_ff;
	smp_hold_type        hold_ff, nxt_hold;

	wire take_req  = req_valid & req_ready_ff;
	wire driving   = (hold_ff == HOLD_IDLE) | (hold_ff == HOLD_DRAIN);
	wire issue     = mem_rise & pend_ff & driving;
	wire nxt_pend  = take_req | (pend_ff & ~issue);
	wire p_rw      = (p_cmd_ff == CMD_READ) | (p_cmd_ff == CMD_WRITE);
	// sram has no command set, so only reads and writes start a cycle
	wire p_valid   = p_sd_ff | p_rw;
	wire nxt_ready = ~nxt_pend & (nxt_hold == HOLD_IDLE);

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			pend_ff      <= 1'b0;
			req_ready_ff <= 1'b0;
		end else if (clk_en) begin
			pend_ff      <= nxt_pend;
			req_ready_ff <= nxt_ready;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			p_cmd_ff  <= CMD_NOP;
			p_sd_ff   <= 1'b0;
			p_cs_ff   <= 2'h0;
			p_addr_ff <= ADDR_RST;
			p_be_ff   <= BE_IDLE;
		end else if (clk_en && take_req) begin
			p_cmd_ff  <= req_cmd;
			p_sd_ff   <= req_sdram;
			p_cs_ff   <= req_cs;
			p_addr_ff <= req_addr;
			p_be_ff   <= req_be_n;
		end
	end

	////////////////////////////////////////////////////////////////////
	// burst sequencing on the memory's own counter

	logic                burst_ff, bwr_ff, bsd_ff;
	logic [1:0]          beat_ff;
	logic [RD_PIPE_W-1:0] rd_pipe_ff;

	localparam logic [1:0] LAST_BEAT = 2'(BURST_LEN - 1);

	// a new command at any beat replaces the burst in flight
	wire issue_rw = issue & p_valid & p_rw;
	wire cont     = burst_ff & (beat_ff != LAST_BEAT) & ~issue;
	wire wr_now   = (issue_rw & (p_cmd_ff == CMD_WRITE)) | (cont & bwr_ff);
	wire rd_now   = (issue_rw & (p_cmd_ff == CMD_READ)) | (cont & ~bwr_ff);
	wire rd_tap   = bsd_ff ? rd_pipe_ff[SD_CAS_LAT-1]
	                       : rd_pipe_ff[SS_RD_LAT-1];
	wire busy     = pend_ff | burst_ff | (|rd_pipe_ff);

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			burst_ff   <= 1'b0;
			bwr_ff     <= 1'b0;
			bsd_ff     <= 1'b0;
			beat_ff    <= 2'h0;
			rd_pipe_ff <= '0;
		end else if (mem_rise) begin
			burst_ff   <= issue ? issue_rw : cont;
			beat_ff    <= issue ? 2'h0 : beat_ff + 2'h1;
			bwr_ff     <= issue ? (p_cmd_ff == CMD_WRITE) : bwr_ff;
			bsd_ff     <= issue ? p_sd_ff : bsd_ff;
			rd_pipe_ff <= {rd_pipe_ff[RD_PIPE_W-2:0], rd_now};
		end
	end

	////////////////////////////////////////////////////////////////////
	// user side data strobes

	logic                rd_valid_ff, wr_take_ff;
	logic [DATA_W-1:0]   rd_data_ff;

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			rd_valid_ff <= 1'b0;
			wr_take_ff  <= 1'b0;
			rd_data_ff  <= DATA_RST;
		end else if (clk_en) begin
			rd_valid_ff <= mem_rise & rd_tap;
			wr_take_ff  <= mem_rise & wr_now;
			if (mem_rise && rd_tap)
				rd_data_ff <= din_s2_ff;
		end
	end

	////////////////////////////////////////////////////////////////////
	// pin decode

	logic [CS_W-1:0]     cs_ff, nxt_cs;
	logic [BE_W-1:0]     be_ff, nxt_be;
	logic [ADDR_W-1:0]   addr_ff, nxt_addr;
	logic [DATA_W-1:0]   dout_ff, nxt_dout;
	logic                doe_n_ff, nxt_doe_n;
	logic                rdp_ff, oep_ff, wrp_ff;
	logic                nxt_rdp, nxt_oep, nxt_wrp;
	logic [2:0]          sd_code;

	// float only moves on memory edges, so the data enable can carry it
	wire                 nxt_float = (nxt_hold == HOLD_FLOAT) |
	                                 (nxt_hold == HOLD_GRANTED) |
	                                 (nxt_hold == HOLD_REDRIVE);

	always_comb begin
		case (p_cmd_ff)
			CMD_READ:  sd_code = SD_READ;
			CMD_WRITE: sd_code = SD_WRITE;
			CMD_ROW_ACTIVATE_CMD:  sd_code = SD_ROW_ACTIVATE_CMD;
			CMD_PREA:  sd_code = SD_PRE;
			CMD_DEACT: sd_code = SD_PRE;
			CMD_REFRESH_CMD:  sd_code = SD_REFRESH_CMD;
			CMD_MRS:   sd_code = SD_MRS;
			default:   sd_code = SD_NOP;
		endcase
	end

	always_comb begin
		nxt_cs    = CS_IDLE;
		nxt_be    = be_ff;
		nxt_addr  = addr_ff;
		nxt_dout  = dout_ff;
		nxt_doe_n = 1'b1;
		nxt_rdp   = 1'b1;
		nxt_oep   = 1'b1;
		nxt_wrp   = 1'b1;
		if (issue && p_valid) begin
			nxt_cs   = ~(CS_W'(1) << p_cs_ff);
			nxt_be   = p_be_ff;
			nxt_addr = p_addr_ff;
			if (p_cmd_ff == CMD_PREA)
				nxt_addr[PRE_ALL_BIT] = 1'b1;
			if (p_cmd_ff == CMD_DEACT)
				nxt_addr[PRE_ALL_BIT] = 1'b0;
			if (p_sd_ff) begin
				{nxt_oep, nxt_rdp, nxt_wrp} = sd_code;
			end else begin
				nxt_rdp = 1'b0;
				nxt_oep = (p_cmd_ff != CMD_READ);
				nxt_wrp = (p_cmd_ff != CMD_WRITE);
			end
		end else if (cont) begin
			nxt_cs = cs_ff;
			// sdram sees nop; sram keeps its enables for the next word
			if (!bsd_ff) begin
				nxt_oep = bwr_ff;
				nxt_wrp = ~bwr_ff;
			end
		end
		if (wr_now) begin
			nxt_dout  = wr_data;
			nxt_doe_n = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			cs_ff    <= CS_IDLE;
			be_ff    <= BE_IDLE;
			addr_ff  <= ADDR_RST;
			dout_ff  <= DATA_RST;
			doe_n_ff <= 1'b1;
			rdp_ff   <= 1'b1;
			oep_ff   <= 1'b1;
			wrp_ff   <= 1'b1;
		end else if (mem_rise) begin
			cs_ff    <= nxt_cs;
			be_ff    <= nxt_be;
			addr_ff  <= nxt_addr;
			dout_ff  <= nxt_dout;
			doe_n_ff <= nxt_doe_n | nxt_float;
			rdp_ff   <= nxt_rdp;
			oep_ff   <= nxt_oep;
			wrp_ff   <= nxt_wrp;
		end
	end

	////////////////////////////////////////////////////////////////////
	// bus hold handshake, counted in memory clock edges

	logic [2:0]          ecnt_ff;
	logic                float_ff, grant_n_ff;

	wire req_low  = ~breq_s2_ff;
	wire cnt_ok   = (ecnt_ff >= FLOAT_MIN_E - 3'h1);
	wire back_ok  = (ecnt_ff >= REDRIVE_MIN_E - 3'h1);

	always_comb begin
		nxt_hold = hold_ff;
		case (hold_ff)
			HOLD_IDLE:
				if (req_low && !hold_refuse)
					nxt_hold = HOLD_DRAIN;
			HOLD_DRAIN:
				if (!req_low)
					nxt_hold = HOLD_IDLE;
				else if (mem_rise && cnt_ok && !busy)
					nxt_hold = HOLD_FLOAT;
			HOLD_FLOAT:
				if (mem_rise)
					nxt_hold = HOLD_GRANTED;
			HOLD_GRANTED:
				if (mem_rise && !req_low && back_ok)
					nxt_hold = HOLD_REDRIVE;
			HOLD_REDRIVE:
				if (mem_rise)
					nxt_hold = HOLD_IDLE;
			default:
				nxt_hold = HOLD_IDLE;
		endcase
	end

	// counter restarts on each state change and while request is low in granted
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			hold_ff    <= HOLD_IDLE;
			ecnt_ff    <= 3'h0;
			float_ff   <= 1'b0;
			grant_n_ff <= 1'b1;
		end else if (clk_en) begin
			hold_ff    <= nxt_hold;
			if (nxt_hold != hold_ff ||
			    (hold_ff == HOLD_GRANTED && req_low))
				ecnt_ff <= 3'h0;
			else if (mem_rise && ecnt_ff != 3'h7)
				ecnt_ff <= ecnt_ff + 3'h1;
			float_ff   <= nxt_float;
			grant_n_ff <= ~((nxt_hold == HOLD_GRANTED) |
			                (nxt_hold == HOLD_REDRIVE));
		end
	end

	assign mem_clk_out     = mck_out_ff;
	assign req_ready       = req_ready_ff;
	assign wr_take         = wr_take_ff;
	assign rd_data         = rd_data_ff;
	assign rd_valid        = rd_valid_ff;
	assign chip_select_n   = cs_ff;
	assign byte_enable_n   = be_ff;
	assign ext_addr        = addr_ff;
	assign ext_data_out    = dout_ff;
	assign ext_data_oe_n   = doe_n_ff;
	assign rd_strobe_pin_n = rdp_ff;
	assign oe_strobe_pin_n = oep_ff;
	assign wr_strobe_pin_n = wrp_ff;
	assign bus_oe_n        = float_ff;
	assign ext_bus_grant_n = grant_n_ff;

	////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	a_pins_on_edge: assert property (
		!$rose(mck_out_ff) |-> $stable(cs_ff) && $stable(addr_ff) &&
		$stable(rdp_ff) && $stable(wrp_ff) && $stable(oep_ff))
		else $error("memory pins moved off a rising mem_clk_out");

	a_sd_read_code: assert property (
		issue && p_sd_ff && p_cmd_ff == CMD_READ |=>
		{oep_ff, rdp_ff, wrp_ff} == SD_READ)
		else $error("sdram read command wrongly encoded");

	a_sram_strobe: assert property (
		issue && !p_sd_ff && p_cmd_ff == CMD_WRITE |=>
		!rdp_ff && !wrp_ff && oep_ff)
		else $error("sram write strobes wrong");

	a_burst_ends: assert property (
		mem_rise && burst_ff && beat_ff == LAST_BEAT && !issue |=>
		!burst_ff)
		else $error("burst ran past four words");

	a_drain_first: assert property (
		$rose(float_ff) |-> !$past(busy))
		else $error("bus floated with work pending");

	a_float_min: assert property (
		$rose(float_ff) |-> $past(ecnt_ff) >= FLOAT_MIN_E - 3'h1)
		else $error("bus floated too early");

	a_grant_soon: assert property (
		$rose(float_ff) |-> ##[1:30] !grant_n_ff)
		else $error("grant late after float");

	a_no_overlap: assert property (
		!grant_n_ff |-> float_ff)
		else $error("grant while bus driven");

	a_refuse_hold: assert property (
		hold_refuse && hold_ff == HOLD_IDLE |=> hold_ff == HOLD_IDLE)
		else $error("hold taken while refused");

	a_release_soon: assert property (
		$fell(float_ff) |-> ##[1:30] grant_n_ff)
		else $error("grant not returned after redrive");

	c_sd_read: cover property (rd_valid_ff && bsd_ff);
	c_cut_burst: cover property (issue_rw && burst_ff);
	c_hold_cycle: cover property ($rose(grant_n_ff));

endmodule : smp_mem_port

// [sim/smp_mem_model.sv]
// memory model: sdram and burst sram data, command and write capture
`timescale 1ns/1ps

module smp_mem_model
	import smp_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              sdram,
	input  wire logic              mem_clk_out,
	input  wire logic [CS_W-1:0]   chip_select_n,
	input  wire logic [ADDR_W-1:0] ext_addr,
	input  wire logic [2:0]        pins_n,
	input  wire logic [DATA_W-1:0] ext_data_out,
	input  wire logic              ext_data_oe_n,
	output logic [DATA_W-1:0]      ext_data_in
);

	logic [DATA_W-1:0] sched [int];
	logic [3:0]        cmd_q [$];
	logic [DATA_W-1:0] wr_q  [$];
	logic              mclk_q = 1'b0;
	int                n = 0;
	int                lat;
	logic              sel;

	initial ext_data_in = 16'h5a5a;

	////////////////////////////////////////////////////////////////////////
	// pins are looked at once settled after each rising memory clock
	always @(negedge ref_clk) begin
		mclk_q <= mem_clk_out;
		if (mem_clk_out && !mclk_q) begin
			n++;
			sel = chip_select_n != CS_IDLE;
			if (sel && (sdram ? pins_n != SD_NOP : !pins_n[1]))
				cmd_q.push_back({ext_addr[PRE_ALL_BIT], pins_n});
			lat = sdram ? SD_CAS_LAT : SS_RD_LAT;
			// a later read overwrites the tail of the earlier one
			if (sel && pins_n == (sdram ? SD_READ : 3'h1))
				for (int k = 0; k < BURST_LEN; k++)
					sched[n + lat + k] = ext_addr[15:0] + 16'(k);
			if (!ext_data_oe_n)
				wr_q.push_back(ext_data_out);
			// no word due: toggle so a stale sample cannot match
			ext_data_in <= sched.exists(n + 1) ? sched[n + 1] : ~ext_data_in;
		end
	end

endmodule : smp_mem_model

// [sim/testbench.sv]
// self-checking bench of the synchronous memory port
`timescale 1ns/1ps

module testbench
	import smp_pkg::*;
;

	logic              ref_clk, rst_b, mem_clk_in, mem_clk_out;
	logic              req_valid, req_ready, req_sdram, wr_take, rd_valid;
	logic              ext_data_oe_n, bus_oe_n, hold_refuse;
	logic              rd_strobe_pin_n, oe_strobe_pin_n, wr_strobe_pin_n;
	logic              ext_bus_req_n, ext_bus_grant_n, mclk_q;
	smp_cmd_type       req_cmd;
	logic [1:0]        req_cs;
	logic [ADDR_W-1:0] req_addr, ext_addr;
	logic [BE_W-1:0]   req_be_n, byte_enable_n;
	logic [DATA_W-1:0] wr_data, rd_data, ext_data_out, ext_data_in;
	logic [CS_W-1:0]   chip_select_n;
	logic [46:0]       pins_q;
	logic [DATA_W-1:0] rd_q [$];
	int                n_errors, n_compared;

	wire [46:0] pins = {chip_select_n, byte_enable_n, ext_addr,
		oe_strobe_pin_n, rd_strobe_pin_n, wr_strobe_pin_n,
		ext_data_out, ext_data_oe_n, bus_oe_n};

	smp_mem_port DUT (.ref_clk, .rst_b, .clk_en(1'b1), .mem_clk_in,
		.mem_clk_out, .req_valid, .req_ready, .req_cmd, .req_sdram, .req_cs,
		.req_addr, .req_be_n, .wr_data, .wr_take, .rd_data, .rd_valid,
		.chip_select_n, .byte_enable_n, .ext_addr, .ext_data_out,
		.ext_data_in, .ext_data_oe_n, .rd_strobe_pin_n, .oe_strobe_pin_n,
		.wr_strobe_pin_n, .bus_oe_n, .hold_refuse, .ext_bus_req_n,
		.ext_bus_grant_n);

	smp_mem_model mdl (.ref_clk, .sdram(req_sdram), .mem_clk_out,
		.chip_select_n, .ext_addr,
		.pins_n({oe_strobe_pin_n, rd_strobe_pin_n, wr_strobe_pin_n}),
		.ext_data_out, .ext_data_oe_n, .ext_data_in);

	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	// link clock unrelated in phase to the system clock
	initial begin
		mem_clk_in = 1'b0;
		#7.3;
		forever #24 mem_clk_in = ~mem_clk_in;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict

	task automatic issue(input smp_cmd_type c, input logic sd,
		input logic [ADDR_W-1:0] a);
		int i = 0;
		@(posedge ref_clk);
		req_valid <= 1'b1;
		req_cmd   <= c;
		req_sdram <= sd;
		req_addr  <= a;
		do begin
			@(posedge ref_clk);
			i++;
		end while (req_ready !== 1'b1 && i < 400);
		req_valid <= 1'b0;
		if (i >= 400)
			chk("request taken", 1, 0);
	endtask : issue

	task automatic wait_rd(input int n);
		for (int i = 0; i < 300 && rd_q.size() < n; i++)
			@(posedge ref_clk);
		repeat (40) @(posedge ref_clk);
	endtask : wait_rd

	////////////////////////////////////////////////////////////////////////
	always @(posedge ref_clk)
		if (rd_valid === 1'b1)
			rd_q.push_back(rd_data);

	always @(posedge ref_clk)
		if (wr_take === 1'b1)
			wr_data <= wr_data + 16'h0001;

	always @(negedge ref_clk) begin
		if (rst_b && pins !== pins_q && !(mem_clk_out && !mclk_q))
			chk("pins off memory edge", 0, 1);
		if (ext_bus_grant_n === 1'b0 && bus_oe_n !== 1'b1)
			chk("grant while driving", 0, 1);
		pins_q <= pins;
		mclk_q <= mem_clk_out;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic t_read(input logic sd, input logic [2:0] code);
		rd_q.delete();
		mdl.cmd_q.delete();
		issue(CMD_READ, sd, 20'h01230);
		wait_rd(4);
		chk("read strobes", {1'b0, code}, mdl.cmd_q[0]);
		chk("read words", 4, rd_q.size());
		for (int k = 0; k < 4; k++)
			chk("read data", 16'h1230 + k, rd_q[k]);
	endtask : t_read

	task automatic t_write(input logic sd);
		mdl.wr_q.delete();
		mdl.cmd_q.delete();
		wr_data <= 16'hc0de;
		issue(CMD_WRITE, sd, 20'h00040);
		repeat (80) @(posedge ref_clk);
		chk("write strobes", 4'h4, mdl.cmd_q[0]);
		chk("write words", 4, mdl.wr_q.size());
		for (int k = 0; k < 4; k++)
			chk("write data", 16'hc0de + k, mdl.wr_q[k]);
	endtask : t_write

	task automatic t_cmds;
		smp_cmd_type c[5] = '{CMD_ROW_ACTIVATE_CMD, CMD_PREA, CMD_DEACT, CMD_REFRESH_CMD, CMD_MRS};
		logic [3:0]  e[5] = '{4'h3, 4'ha, 4'h2, 4'h1, 4'h0};
		mdl.cmd_q.delete();
		// deactivate is sent with line 10 set, it must come out clear
		for (int k = 0; k < 5; k++)
			issue(c[k], 1'b1, (k == 2) ? 20'h00100 : 20'h00000);
		repeat (30) @(posedge ref_clk);
		for (int k = 0; k < 5; k++)
			chk("sdram command", e[k], mdl.cmd_q[k]);
	endtask : t_cmds

	task automatic t_cut;
		rd_q.delete();
		issue(CMD_READ, 1'b1, 20'h00100);
		issue(CMD_READ, 1'b1, 20'h000f0);
		wait_rd(5);
		chk("cut words", 5, rd_q.size());
		chk("cut head", 16'h0100, rd_q[0]);
		for (int k = 0; k < 4; k++)
			chk("cut data", 16'h00f0 + k, rd_q[k + 1]);
	endtask : t_cut

	task automatic t_hold(input logic busy);
		realtime t0, t1;
		int i;
		rd_q.delete();
		if (busy)
			issue(CMD_READ, 1'b1, 20'h00200);
		@(posedge mem_clk_in);
		@(posedge ref_clk);
		ext_bus_req_n <= 1'b0;
		t0 = $realtime;
		for (i = 0; i < 300 && bus_oe_n !== 1'b1; i++) @(posedge ref_clk);
		t1 = $realtime;
		if (busy)
			chk("drained first", 4, rd_q.size());
		else
			chk("float delay", 1, t1 - t0 >= 96.0 && t1 - t0 <= 150.0);
		for (i = 0; i < 300 && ext_bus_grant_n !== 1'b0; i++) @(posedge ref_clk);
		chk("grant delay", 1, $realtime - t1 <= 96.0);
		chk("floated", 3'h6, {bus_oe_n, ext_data_oe_n, req_ready});
		// master keeps the request a while past the grant
		repeat (2) @(posedge mem_clk_in);
		@(posedge ref_clk);
		ext_bus_req_n <= 1'b1;
		t0 = $realtime;
		for (i = 0; i < 300 && bus_oe_n !== 1'b0; i++) @(posedge ref_clk);
		t1 = $realtime;
		chk("redrive delay", 1, t1 - t0 >= 96.0 && t1 - t0 <= 336.0);
		for (i = 0; i < 300 && ext_bus_grant_n !== 1'b1; i++) @(posedge ref_clk);
		chk("ungrant delay", 1, $realtime - t1 <= 96.0);
	endtask : t_hold

	task automatic t_refuse;
		@(posedge ref_clk);
		hold_refuse   <= 1'b1;
		ext_bus_req_n <= 1'b0;
		repeat (200) @(posedge ref_clk);
		chk("refused hold", 2'h1, {bus_oe_n, ext_bus_grant_n});
		ext_bus_req_n <= 1'b1;
		repeat (20) @(posedge ref_clk);
		hold_refuse <= 1'b0;
	endtask : t_refuse

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_errors++;
		$display("[FAIL] watchdog expected done seen hang");
		print_verdict;
	end

	initial begin
		n_errors = 0;
		n_compared = 0;
		rst_b = 1'b0;
		req_valid = 1'b0;
		req_cmd = CMD_NOP;
		req_sdram = 1'b1;
		req_cs = 2'h1;
		req_addr = 20'h00000;
		req_be_n = 2'h0;
		wr_data = 16'h0000;
		hold_refuse = 1'b0;
		ext_bus_req_n = 1'b1;
		repeat (20) @(posedge ref_clk);
		chk("reset pins", {CS_IDLE, BE_IDLE}, {chip_select_n, byte_enable_n});
		rst_b <= 1'b1;
		repeat (2) @(posedge ref_clk);
		t_read(1'b1, SD_READ);
		t_read(1'b0, 3'h1);
		t_write(1'b1);
		t_write(1'b0);
		t_cmds;
		t_cut;
		t_hold(1'b0);
		t_hold(1'b1);
		t_refuse;
		t_read(1'b1, SD_READ);
		print_verdict;
	end

endmodule : testbench
